//--- start_stop_defs.vh
// Purpose: constants for the start/stop sequencer
// Assumes: 40 MHz ref_clk, settings in 0.1 s, 0.01 Hz and percent units
// Notes: definitions only
`ifndef START_STOP_DEFS_VH
`define START_STOP_DEFS_VH
// ==========================================
// clock and time base
`define CLK_HZ 40000000
`define TICK_S_TENTHS 1
`define TICK_CYCLES (`CLK_HZ / 10 * `TICK_S_TENTHS)
// ==========================================
// start mode codes
`define START_DIRECT 2'h0
`define START_TRACK 2'h1
`define START_PREEXCITE 2'h2
`define START_PREEXCITE_ALT 2'h3
// ==========================================
// tracking origin codes
`define ORIGIN_STOP_FREQ 2'h0
`define ORIGIN_ZERO 2'h1
`define ORIGIN_MAX 2'h2
// ==========================================
// stop modes
`define HALT_DECEL 1'h0
`define HALT_COAST 1'h1
// ==========================================
// ranges and defaults
`define FREQ_W 16
`define TIME_W 10
`define PCT_W 7
`define PCT_MAX 7'h64
`define LAUNCH_FREQ_MAX 16'h03E8
`define TIME_MAX 10'h3E8
`define RATE_MIN 7'h01
`define RATE_MAX 7'h64
`define RATE_DEFAULT 7'h14
`endif

//--- motor_start_stop_sequencer.v
// Purpose: start and stop phase sequencer for an inverter motor drive
// Assumes: settings are static while running; ramp generator lies outside
// Notes: frequencies in 0.01 Hz, times in 0.1 s, currents in percent
//
// Summary of operation
// - start mode 0 direct, 1 speed tracking, 2 pre-excited start.
// - tracking origin 0 stop frequency, 1 zero speed, 2 maximum frequency.
// - tracking rate 1..100, default 20; larger value tracks faster.
// - output startup frequency and hold it for hold time before accelerating, except after speed tracking.
// - startup frequency is not clamped by the frequency lower limit.
// - target below startup frequency: do not start, hold with zero output.
// - hold time skipped during forward/reverse transition.
// - hold excluded from acceleration time, counted in PLC step time.
// - startup DC braking only in direct start, current for time, then hold or run.
// - zero startup braking time skips braking, goes straight to hold or run.
// - pre-excited start builds field at set current for set time.
// - zero pre-excitation time skips pre-excitation.
// - startup braking and pre-excitation current are percent of rated current.
// - stop mode 0 ramps down at deceleration time, stops at zero.
// - stop mode 1 cuts output immediately, motor coasts.
// - decelerating below braking start frequency begins stop DC braking.
// - output disabled for waiting time before stop braking current.
// - stop braking drives configured current, percent of rated current.
// - stop braking held for braking time; zero cancels braking.
`include "start_stop_defs.vh"

module motor_start_stop_sequencer #(
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter FW = `FREQ_W,
   parameter TW = `TIME_W,
   parameter PW = `PCT_W
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // commands
   input wire run_cmd,
   input wire dir_reverse,
   input wire dir_changing,
   input wire [FW-1:0] target_freq,
   input wire [FW-1:0] max_freq,
   input wire [FW-1:0] stop_freq_mem,
   input wire [FW-1:0] ramp_freq,
   input wire tracking_locked,
   // start settings
   input wire [1:0] start_mode_select,
   input wire [1:0] tracking_origin_select,
   input wire [PW-1:0] tracking_rate,
   input wire [FW-1:0] launch_frequency,
   input wire [TW-1:0] launch_hold_time,
   input wire [PW-1:0] launch_brake_or_excite_current,
   input wire [TW-1:0] launch_brake_or_excite_time,
   // stop settings
   input wire halt_mode_select,
   input wire [FW-1:0] halt_brake_start_freq,
   input wire [TW-1:0] halt_brake_wait_time,
   input wire [PW-1:0] halt_brake_current,
   input wire [TW-1:0] halt_brake_duration,
   // outputs to power stage and ramp generator
   output reg [FW-1:0] freq_ref,
   output reg [PW-1:0] dc_current_pct,
   output reg output_enable,
   output reg ramp_enable,
   output reg ramp_decel,
   output reg accel_timing,
   output reg plc_step_timing,
   output reg [FW-1:0] search_start_freq,
   output reg [PW-1:0] search_rate,
   output reg tracking_active,
   output reg [3:0] seq_state
);

   // ==========================================
   // state codes, one-hot
   localparam S_IDLE = 10'h001;
   localparam S_WAITSET = 10'h002;
   localparam S_LBRAKE = 10'h004;
   localparam S_EXCITE = 10'h008;
   localparam S_TRACK = 10'h010;
   localparam S_HOLD = 10'h020;
   localparam S_RUN = 10'h040;
   localparam S_DECEL = 10'h080;
   localparam S_HWAIT = 10'h100;
   localparam S_HBRAKE = 10'h200;

   reg [9:0] state_reg;
   reg [9:0] state_next;
   reg [TW-1:0] timer_reg;
   reg [TW-1:0] timer_next;
   reg [31:0] div_reg;
   reg tick;
   wire [PW-1:0] rate_clamped;
   wire [PW-1:0] launch_pct;
   wire [PW-1:0] halt_pct;

   // ==========================================
   // 0.1 s tick divider; free running so tick phase is not aligned to phase entry
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         div_reg <= 32'h0;
         tick <= 1'b0;
      end else if (div_reg >= TICK_CYCLES - 1) begin
         div_reg <= 32'h0;
         tick <= 1'b1;
      end else begin
         div_reg <= div_reg + 32'h1;
         tick <= 1'b0;
      end
   end

   // rate and current settings limited to their legal ranges
   assign rate_clamped = (tracking_rate < `RATE_MIN) ? `RATE_MIN :
                         (tracking_rate > `RATE_MAX) ? `RATE_MAX : tracking_rate;
   assign launch_pct = (launch_brake_or_excite_current > `PCT_MAX) ? `PCT_MAX :
                       launch_brake_or_excite_current;
   assign halt_pct = (halt_brake_current > `PCT_MAX) ? `PCT_MAX : halt_brake_current;

   // ==========================================
   // sequencer next state; timer reloads on entry, counts down on tick
   always @* begin
      state_next = state_reg;
      timer_next = timer_reg;
      if (tick && timer_reg != {TW{1'b0}})
         timer_next = timer_reg - {{(TW-1){1'b0}}, 1'b1};
      case (state_reg)
         S_IDLE: begin
            if (run_cmd)
               state_next = S_WAITSET;
         end
         S_WAITSET: begin
            if (!run_cmd) begin
               state_next = S_IDLE;
            end else if (target_freq < launch_frequency) begin
               state_next = S_WAITSET;
            end else if (start_mode_select == `START_DIRECT &&
                         launch_brake_or_excite_time != {TW{1'b0}}) begin
               state_next = S_LBRAKE;
               timer_next = launch_brake_or_excite_time;
            end else if ((start_mode_select == `START_PREEXCITE ||
                          start_mode_select == `START_PREEXCITE_ALT) &&
                         launch_brake_or_excite_time != {TW{1'b0}}) begin
               state_next = S_EXCITE;
               timer_next = launch_brake_or_excite_time;
            end else if (start_mode_select == `START_TRACK) begin
               state_next = S_TRACK;
            end else if (dir_changing || launch_hold_time == {TW{1'b0}}) begin
               state_next = S_RUN;
            end else begin
               state_next = S_HOLD;
               timer_next = launch_hold_time;
            end
         end
         S_LBRAKE, S_EXCITE: begin
            if (!run_cmd) begin
               state_next = S_IDLE;
            end else if (timer_reg == {TW{1'b0}}) begin
               if (dir_changing || launch_hold_time == {TW{1'b0}}) begin
                  state_next = S_RUN;
               end else begin
                  state_next = S_HOLD;
                  timer_next = launch_hold_time;
               end
            end
         end
         S_TRACK: begin
            if (!run_cmd)
               state_next = S_IDLE;
            else if (tracking_locked)
               state_next = S_RUN;
         end
         S_HOLD: begin
            if (!run_cmd)
               state_next = S_IDLE;
            else if (dir_changing || timer_reg == {TW{1'b0}})
               state_next = S_RUN;
         end
         S_RUN: begin
            if (!run_cmd) begin
               if (halt_mode_select == `HALT_COAST)
                  state_next = S_IDLE;
               else
                  state_next = S_DECEL;
            end
         end
         S_DECEL: begin
            if (run_cmd) begin
               state_next = S_RUN;
            end else if (halt_brake_duration != {TW{1'b0}} &&
                         (ramp_freq < halt_brake_start_freq ||
                          ramp_freq == {FW{1'b0}})) begin
               // a zero start frequency still brakes once the ramp reaches zero
               state_next = S_HWAIT;
               timer_next = halt_brake_wait_time;
            end else if (ramp_freq == {FW{1'b0}}) begin
               state_next = S_IDLE;
            end
         end
         S_HWAIT: begin
            if (timer_reg == {TW{1'b0}}) begin
               state_next = S_HBRAKE;
               timer_next = halt_brake_duration;
            end
         end
         S_HBRAKE: begin
            if (timer_reg == {TW{1'b0}})
               state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // state and timer registers
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg <= S_IDLE;
         timer_reg <= {TW{1'b0}};
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
      end
   end

   // ==========================================
   // registered outputs decoded from the next state, so they track the state
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         freq_ref <= {FW{1'b0}};
         dc_current_pct <= {PW{1'b0}};
         output_enable <= 1'b0;
         ramp_enable <= 1'b0;
         ramp_decel <= 1'b0;
         accel_timing <= 1'b0;
         plc_step_timing <= 1'b0;
         search_start_freq <= {FW{1'b0}};
         search_rate <= `RATE_DEFAULT;
         tracking_active <= 1'b0;
         seq_state <= 4'h0;
      end else begin
         freq_ref <= {FW{1'b0}};
         dc_current_pct <= {PW{1'b0}};
         output_enable <= 1'b0;
         ramp_enable <= 1'b0;
         ramp_decel <= 1'b0;
         accel_timing <= 1'b0;
         plc_step_timing <= 1'b0;
         tracking_active <= 1'b0;
         search_rate <= rate_clamped;
         case (tracking_origin_select)
            `ORIGIN_ZERO: search_start_freq <= {FW{1'b0}};
            `ORIGIN_MAX: search_start_freq <= max_freq;
            default: search_start_freq <= stop_freq_mem;
         endcase
         case (state_next)
            S_WAITSET: seq_state <= 4'h1;
            S_LBRAKE: begin
               seq_state <= 4'h2;
               output_enable <= 1'b1;
               dc_current_pct <= launch_pct;
            end
            S_EXCITE: begin
               seq_state <= 4'h3;
               output_enable <= 1'b1;
               dc_current_pct <= launch_pct;
            end
            S_TRACK: begin
               seq_state <= 4'h4;
               output_enable <= 1'b1;
               tracking_active <= 1'b1;
            end
            S_HOLD: begin
               seq_state <= 4'h5;
               output_enable <= 1'b1;
               freq_ref <= launch_frequency;
               plc_step_timing <= 1'b1;
            end
            S_RUN: begin
               seq_state <= 4'h6;
               output_enable <= 1'b1;
               ramp_enable <= 1'b1;
               freq_ref <= (target_freq > launch_frequency) ? target_freq : launch_frequency;
               accel_timing <= 1'b1;
               plc_step_timing <= 1'b1;
            end
            S_DECEL: begin
               seq_state <= 4'h7;
               output_enable <= 1'b1;
               ramp_enable <= 1'b1;
               ramp_decel <= 1'b1;
            end
            S_HWAIT: seq_state <= 4'h8;
            S_HBRAKE: begin
               seq_state <= 4'h9;
               output_enable <= 1'b1;
               dc_current_pct <= halt_pct;
            end
            default: seq_state <= 4'h0;
         endcase
      end
   end

endmodule // motor_start_stop_sequencer

//--- motor_start_stop_sequencer_chk.sv
// Purpose: port-level assertions for the start/stop sequencer
// Assumes: default parameter widths, settings static while a cycle runs
// Notes: seq_state codes 0 idle .. 9 haltbrake
// ==========================================
// checker
module motor_start_stop_sequencer_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // watched inputs
   input wire logic run_cmd,
   input wire logic halt_mode_select,
   input wire logic [1:0] start_mode_select,
   input wire logic [15:0] target_freq,
   input wire logic [15:0] launch_frequency,
   input wire logic [15:0] ramp_freq,
   input wire logic [15:0] halt_brake_start_freq,
   input wire logic [6:0] launch_brake_or_excite_current,
   input wire logic [6:0] halt_brake_current,
   input wire logic [6:0] tracking_rate,
   input wire logic [9:0] halt_brake_duration,
   // watched outputs
   input wire logic [15:0] freq_ref,
   input wire logic [6:0] dc_current_pct,
   input wire logic output_enable,
   input wire logic accel_timing,
   input wire logic plc_step_timing,
   input wire logic [6:0] search_rate,
   input wire logic [3:0] seq_state
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // stop requests seen while running; the mode picks the path
   sequence coast_req;
      seq_state == 4'h6 && halt_mode_select && !run_cmd;
   endsequence
   sequence decel_req;
      seq_state == 4'h6 && !halt_mode_select && !run_cmd;
   endsequence
   refuse_zero_a: assert property ((seq_state == 4'h1 && target_freq < launch_frequency) [*2]
      |-> freq_ref == 16'h0000) else $error("refused start drives frequency");
   brake_mode_a: assert property (seq_state == 4'h2 |-> start_mode_select == 2'h0
      && dc_current_pct == launch_brake_or_excite_current) else $error("start brake wrong");
   excite_mode_a: assert property (seq_state == 4'h3 |-> start_mode_select[1]
      && dc_current_pct == launch_brake_or_excite_current) else $error("excite wrong");
   track_rate_a: assert property (seq_state == 4'h4 |-> search_rate == tracking_rate)
      else $error("tracking rate not applied");
   hold_freq_a: assert property (seq_state == 4'h5 |-> freq_ref == launch_frequency
      && !accel_timing && plc_step_timing) else $error("hold phase wrong");
   haltwait_off_a: assert property (seq_state == 4'h8 |-> !output_enable
      && dc_current_pct == 7'h00) else $error("output live in brake wait");
   haltbrake_cur_a: assert property (seq_state == 4'h9 |-> dc_current_pct
      == halt_brake_current) else $error("stop brake current wrong");
   brake_cancel_a: assert property (seq_state == 4'h9 |-> halt_brake_duration != 10'h000)
      else $error("stop brake with zero time");
   coast_cut_a: assert property (coast_req |-> ##[1:3] !output_enable)
      else $error("coast stop kept output");
   decel_go_a: assert property (decel_req |-> ##[1:3] seq_state == 4'h7)
      else $error("no deceleration on stop");
   brake_entry_a: assert property (seq_state == 4'h7 && ramp_freq < halt_brake_start_freq
      && halt_brake_duration != 10'h000 && !run_cmd |-> ##[1:3] seq_state == 4'h8)
      else $error("stop brake not entered");
endmodule // motor_start_stop_sequencer_chk

bind motor_start_stop_sequencer motor_start_stop_sequencer_chk chk_u (
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .run_cmd(run_cmd),
   .halt_mode_select(halt_mode_select),
   .start_mode_select(start_mode_select),
   .target_freq(target_freq),
   .launch_frequency(launch_frequency),
   .ramp_freq(ramp_freq),
   .halt_brake_start_freq(halt_brake_start_freq),
   .launch_brake_or_excite_current(launch_brake_or_excite_current),
   .halt_brake_current(halt_brake_current),
   .tracking_rate(tracking_rate),
   .halt_brake_duration(halt_brake_duration),
   .freq_ref(freq_ref),
   .dc_current_pct(dc_current_pct),
   .output_enable(output_enable),
   .accel_timing(accel_timing),
   .plc_step_timing(plc_step_timing),
   .search_rate(search_rate),
   .seq_state(seq_state)
);

//--- ramp_source_model.sv
// Purpose: ramp generator and speed estimator beside the sequencer
// Assumes: fixed step of 0.50 Hz per clock
// Notes: lock follows tracking one cycle later
// ==========================================
// model
module ramp_source_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // from sequencer
   input wire logic ramp_enable,
   input wire logic ramp_decel,
   input wire logic tracking_active,
   input wire logic [15:0] target_freq,
   // to sequencer
   output logic [15:0] ramp_freq,
   output logic tracking_locked
);
   // short ramps keep the run small; real slopes are far slower
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ramp_freq <= 16'h0000;
         tracking_locked <= 1'b0;
      end else begin
         tracking_locked <= tracking_active;
         if (ramp_decel)
            ramp_freq <= (ramp_freq > 16'h0032) ? ramp_freq - 16'h0032 : 16'h0000;
         else if (ramp_enable)
            ramp_freq <= (ramp_freq < target_freq) ? ramp_freq + 16'h0032 : target_freq;
         else
            ramp_freq <= 16'h0000;
      end
   end
endmodule // ramp_source_model

//--- motor_start_stop_sequencer_tb.sv
// Purpose: directed start/stop cycles through the sequencer
// Assumes: tick of 10 clocks stands for 0.1 s
// Notes: visited states gathered in a bit mask
module motor_start_stop_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, sys_rst = 1, run_cmd = 0, dir_changing = 0, dir_reverse = 0;
   logic halt_mode_select = 0, tracking_locked, output_enable, ramp_enable, ramp_decel;
   logic accel_timing, plc_step_timing, tracking_active;
   logic [15:0] target_freq = 16'h03E8, stop_freq_mem = 16'h0123, max_freq = 16'h1388;
   logic [15:0] launch_frequency = 16'h01F4, halt_brake_start_freq = 16'h012C;
   logic [15:0] ramp_freq, freq_ref, search_start_freq;
   logic [9:0] launch_hold_time = 10'h002, launch_brake_or_excite_time = 10'h000;
   logic [9:0] halt_brake_wait_time = 10'h001, halt_brake_duration = 10'h002, seen;
   logic [6:0] tracking_rate = 7'h32, launch_brake_or_excite_current = 7'h28;
   logic [6:0] halt_brake_current = 7'h3C, dc_current_pct, search_rate;
   logic [1:0] start_mode_select = 0, tracking_origin_select = 0;
   logic [3:0] seq_state;
   int miscompares = 0, total_checks = 0, n;
   // ==========================================
   // design, far side and clock
   motor_start_stop_sequencer #(.TICK_CYCLES(10)) dut_u (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .run_cmd(run_cmd),
      .dir_reverse(dir_reverse),
      .dir_changing(dir_changing),
      .target_freq(target_freq),
      .max_freq(max_freq),
      .stop_freq_mem(stop_freq_mem),
      .ramp_freq(ramp_freq),
      .tracking_locked(tracking_locked),
      .start_mode_select(start_mode_select),
      .tracking_origin_select(tracking_origin_select),
      .tracking_rate(tracking_rate),
      .launch_frequency(launch_frequency),
      .launch_hold_time(launch_hold_time),
      .launch_brake_or_excite_current(launch_brake_or_excite_current),
      .launch_brake_or_excite_time(launch_brake_or_excite_time),
      .halt_mode_select(halt_mode_select),
      .halt_brake_start_freq(halt_brake_start_freq),
      .halt_brake_wait_time(halt_brake_wait_time),
      .halt_brake_current(halt_brake_current),
      .halt_brake_duration(halt_brake_duration),
      .freq_ref(freq_ref),
      .dc_current_pct(dc_current_pct),
      .output_enable(output_enable),
      .ramp_enable(ramp_enable),
      .ramp_decel(ramp_decel),
      .accel_timing(accel_timing),
      .plc_step_timing(plc_step_timing),
      .search_start_freq(search_start_freq),
      .search_rate(search_rate),
      .tracking_active(tracking_active),
      .seq_state(seq_state)
   );
   ramp_source_model far_u (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .ramp_enable(ramp_enable),
      .ramp_decel(ramp_decel),
      .tracking_active(tracking_active),
      .target_freq(target_freq),
      .ramp_freq(ramp_freq),
      .tracking_locked(tracking_locked)
   );
   initial begin
      ref_clk = 0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // states seen at each edge
   always @(posedge ref_clk) seen <= seen | (10'h001 << seq_state);
   // ==========================================
   // tasks
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task close_out();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bounded wait; returns cycles spent
   task waitst(input logic [3:0] s, output int c);
      c = 0;
      while (seq_state !== s && c < 600) begin
         @(posedge ref_clk);
         #2 c++;
      end
      if (c == 600) begin
         miscompares++;
         $display("[ERR] %0t timeout waiting for state %0d", $time, s);
         close_out();
      end
   endtask
   // one start then one stop; settings change only while idle
   task cyc(input logic [1:0] m, input logic [9:0] bt, input logic hm, input logic [9:0] d,
            input logic [9:0] sx, input logic [9:0] px);
      start_mode_select = m;
      launch_brake_or_excite_time = bt;
      halt_mode_select = hm;
      halt_brake_duration = d;
      seen = 0;
      run_cmd = 1;
      if (m == 2'h1) begin
         waitst(4'h4, n);
         chk(search_start_freq, tracking_origin_select == 2'h0 ? stop_freq_mem :
             tracking_origin_select == 2'h1 ? 16'h0000 : max_freq);
         chk(tracking_active, 1'b1);
         chk(search_rate, 7'h32);
      end
      waitst(4'h6, n);
      chk(seen, sx);
      chk(freq_ref, target_freq);
      chk(accel_timing, 1'b1);
      chk(ramp_enable, 1'b1);
      repeat (30) @(posedge ref_clk);
      #2 seen = 0;
      run_cmd = 0;
      if (!hm) begin
         // decel stop must hand the ramp a falling slope
         waitst(4'h7, n);
         chk(ramp_decel, 1'b1);
      end
      waitst(4'h0, n);
      chk(seen, px);
      $display("cycle mode %0d done", m);
   endtask
   // ==========================================
   // sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      // the reset search_rate value is only visible while reset is held
      #2 chk(search_rate, 7'h14);
      chk(seq_state, 4'h0);
      sys_rst = 0;
      @(posedge ref_clk);
      #2 chk(search_rate, 7'h32);
      cyc(2'h0, 10'h002, 0, 10'h002, 10'h027, 10'h3C0);
      cyc(2'h0, 10'h000, 0, 10'h000, 10'h023, 10'h0C0);
      cyc(2'h2, 10'h002, 1, 10'h002, 10'h02B, 10'h040);
      cyc(2'h2, 10'h000, 1, 10'h002, 10'h023, 10'h040);
      for (int i = 0; i < 3; i++) begin
         tracking_origin_select = i[1:0];
         cyc(2'h1, 10'h002, 0, 10'h002, 10'h013, 10'h3C0);
      end
      // long hold normally, skipped on a direction change
      start_mode_select = 2'h0;
      launch_hold_time = 10'h00A;
      for (int d = 0; d < 2; d++) begin
         dir_changing = d[0];
         run_cmd = 1;
         waitst(4'h6, n);
         chk(n >= 90, !d[0]);
         run_cmd = 0;
         waitst(4'h0, n);
      end
      $display("hold test done");
      // target below the launch frequency is refused
      target_freq = 16'h0064;
      run_cmd = 1;
      repeat (40) @(posedge ref_clk);
      #2 chk(seq_state, 4'h1);
      chk(freq_ref, 16'h0000);
      run_cmd = 0;
      waitst(4'h0, n);
      $display("refusal test done");
      close_out();
   end
endmodule // motor_start_stop_sequencer_tb
